/* icn_pkg.sv */
// constants and types for the input change notifier
`default_nettype none
package icn_pkg;
  localparam int          ICN_PINS      = 30;
  localparam int          ICN_HALF      = 16;
  localparam int          ICN_HI_BITS   = ICN_PINS - ICN_HALF;
  localparam logic [15:0] ICN_EN_RST    = 16'h0000;
  localparam logic [15:0] ICN_PU_RST    = 16'h0000;
  localparam logic [29:0] ICN_PIN_RST   = 30'h00000000;
  localparam int          ICN_TCY_NS    = 20;
  localparam int          ICN_CLK_NS    = 10;
  localparam int          ICN_MIN_HOLD_TCY = 2;
  // least input level time in clock cycles, rounded up
  localparam int          ICN_MIN_HOLD_CYC =
    (ICN_MIN_HOLD_TCY * ICN_TCY_NS + ICN_CLK_NS - 1) / ICN_CLK_NS;
  typedef logic [ICN_PINS-1:0] icn_pins_t;
endpackage : icn_pkg
`default_nettype wire

/* icn_sync.sv */
// two-stage synchroniser for the change watch pins
`timescale 1ns/100ps
`default_nettype none
module icn_sync (
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire icn_pkg::icn_pins_t async_i,
  output var  icn_pkg::icn_pins_t sync_o
);
  import icn_pkg::*;
  icn_pins_t meta_r;
  icn_pins_t sync_r;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= ICN_PIN_RST;
      sync_r <= ICN_PIN_RST;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r;
endmodule : icn_sync
`default_nettype wire

/* icn_notifier.sv */
// input change notifier: per-pin change detect, shared sticky flag, pull-up enables
`timescale 1ns/100ps
`default_nettype none
module icn_notifier (
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  input  wire icn_pkg::icn_pins_t change_watch_pin_i,
  input  wire logic [15:0]        change_irq_enable_low_i,
  input  wire logic [15:0]        change_irq_enable_high_i,
  input  wire logic [15:0]        weak_pullup_enable_low_i,
  input  wire logic [15:0]        weak_pullup_enable_high_i,
  input  wire logic               notice_clear_i,
  output var  icn_pkg::icn_pins_t pullup_on_o,
  output var  icn_pkg::icn_pins_t state_change_event_o,
  output var  logic               input_change_notice_o
);
  import icn_pkg::*;

  icn_pins_t pin_sync;
  icn_pins_t sample_r,  sample_nxt;
  icn_pins_t event_r,   event_nxt;
  icn_pins_t pullup_r,  pullup_nxt;
  logic      notice_r,  notice_nxt;
  icn_pins_t enable_all;

  // plain level compare
  // pin inputs are asynchronous to mclk_i
  icn_sync u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (change_watch_pin_i),
    .sync_o    (pin_sync)
  );

  // joins a low and a high control word into one per-pin vector
  function automatic icn_pins_t join_words(input logic [15:0] lo, input logic [15:0] hi);
    join_words = {hi[ICN_HI_BITS-1:0], lo};
  endfunction : join_words

  always_comb begin
    enable_all = join_words(change_irq_enable_low_i, change_irq_enable_high_i);
    pullup_nxt = join_words(weak_pullup_enable_low_i, weak_pullup_enable_high_i);
    sample_nxt = pin_sync;
    event_nxt  = (pin_sync ^ sample_r) & enable_all;
    notice_nxt = (|event_nxt) | (notice_r & ~notice_clear_i);
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_r <= ICN_PIN_RST;
      event_r  <= ICN_PIN_RST;
      pullup_r <= ICN_PIN_RST;
      notice_r <= 1'b0;
    end else begin
      sample_r <= sample_nxt;
      event_r  <= event_nxt;
      pullup_r <= pullup_nxt;
      notice_r <= notice_nxt;
    end
  end

  assign pullup_on_o           = pullup_r;
  assign state_change_event_o  = event_r;
  assign input_change_notice_o = notice_r;

  // first sample after reset is zero: a pin held high reads as one change
  property p_change_sets;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (|(($past(pin_sync) ^ $past(sample_r)) & $past(enable_all))) |-> input_change_notice_o;
  endproperty

  a_change_sets: assert property (p_change_sets) else $error("enabled change did not set notice");

  property p_masked_quiet;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (enable_all == ICN_PIN_RST && !input_change_notice_o) |=> !input_change_notice_o;
  endproperty

  a_masked_quiet: assert property (p_masked_quiet) else $error("notice set with all pins disabled");

  property p_event_masked;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ##1 ((state_change_event_o & ~$past(enable_all)) == ICN_PIN_RST);
  endproperty

  a_event_masked: assert property (p_event_masked) else $error("event on disabled pin");

  property p_pullup;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ##1 (pullup_on_o == $past(join_words(weak_pullup_enable_low_i, weak_pullup_enable_high_i)));
  endproperty

  a_pullup: assert property (p_pullup) else $error("pull-up does not follow enable");

  property p_sample_tracks;
    @(posedge mclk_i) disable iff (sys_rst_i) ##1 (sample_r == $past(pin_sync));
  endproperty

  a_sample_tracks: assert property (p_sample_tracks) else $error("sample not updated");

  // an event bit only where the stored sample really differed
  property p_event_needs_change;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ##1 ((state_change_event_o & ~($past(pin_sync) ^ $past(sample_r))) == ICN_PIN_RST);
  endproperty

  a_event_needs_change: assert property (p_event_needs_change) else $error("event without change");

  // event and notice come from the same compare, so they rise together
  property p_event_gives_notice;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (state_change_event_o != ICN_PIN_RST) |-> input_change_notice_o;
  endproperty

  a_event_gives_notice: assert property (p_event_gives_notice) else $error("event without notice");

  sequence s_notice_rises;
    !input_change_notice_o ##1 input_change_notice_o;
  endsequence

  // a rising request always has a pin event behind it
  property p_notice_has_source;
    @(posedge mclk_i) disable iff (sys_rst_i)
      s_notice_rises |-> (state_change_event_o != ICN_PIN_RST);
  endproperty

  a_notice_has_source: assert property (p_notice_has_source) else $error("notice rose with no event");

  // two flops between pin and compare, never fewer
  property p_sync_depth;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ##2 (pin_sync == $past(change_watch_pin_i, 2));
  endproperty

  a_sync_depth: assert property (p_sync_depth) else $error("synchroniser depth wrong");

  // no disable here: the outputs must be quiet while reset stands
  property p_reset_quiet;
    @(posedge mclk_i)
      sys_rst_i |-> (!input_change_notice_o && state_change_event_o == ICN_PIN_RST && pullup_on_o == ICN_PIN_RST);
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");

  // upper two bits of the high words have no pin behind them
  property p_top_bits_ignored;
    @(posedge mclk_i) disable iff (sys_rst_i)
      ##1 (pullup_on_o[ICN_PINS-1:ICN_HALF] == $past(weak_pullup_enable_high_i[ICN_HI_BITS-1:0]));
  endproperty

  a_top_bits_ignored: assert property (p_top_bits_ignored) else $error("high pull-up word misplaced");

  sequence s_held_no_clear;
    input_change_notice_o && !notice_clear_i;
  endsequence
  property p_sticky;
    @(posedge mclk_i) disable iff (sys_rst_i) s_held_no_clear |=> input_change_notice_o;
  endproperty

  a_sticky: assert property (p_sticky) else $error("notice dropped without clear");


  property p_clear;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (notice_clear_i && (event_nxt == ICN_PIN_RST)) |=> !input_change_notice_o;
  endproperty

  a_clear: assert property (p_clear) else $error("clear did not drop notice");


  property p_set_wins;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (notice_clear_i && (event_nxt != ICN_PIN_RST)) |=> input_change_notice_o;
  endproperty

  a_set_wins: assert property (p_set_wins) else $error("change lost in clear cycle");

  // a stable pin change must reach the request within the sync and compare latency

  property p_pin_to_notice;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (change_watch_pin_i[0] != pin_sync[0] && enable_all[0]) ##1 (change_watch_pin_i[0] == $past(change_watch_pin_i[0]) && enable_all[0])
        |-> ##[1:2] input_change_notice_o;
  endproperty

  a_pin_to_notice: assert property (p_pin_to_notice) else $error("pin change not noticed in time");
endmodule : icn_notifier
`default_nettype wire

/* icn_pin_model.sv */
// buttons and keypads that stand on the change watch pins
`timescale 1ns/100ps
`default_nettype none
module icn_pin_model (
  input  wire icn_pkg::icn_pins_t drv_en_i,
  input  wire icn_pkg::icn_pins_t drv_val_i,
  input  wire icn_pkg::icn_pins_t pullup_on_i,
  output var  icn_pkg::icn_pins_t pin_o
);
  import icn_pkg::*;
  always_comb begin
    // a released pin without pull-up keeps no level: show the inverse
    for (int i = 0; i < ICN_PINS; i++) begin
      pin_o[i] = drv_en_i[i] ? drv_val_i[i] : (pullup_on_i[i] ? 1'b1 : ~drv_val_i[i]);
    end
  end
endmodule : icn_pin_model
`default_nettype wire

/* tb_input_change_notifier.sv */
// self-checking bench of the input change notifier
`timescale 1ns/100ps
`default_nettype none
module tb_input_change_notifier;
  import icn_pkg::*;
  typedef struct {logic [15:0] lo; logic [15:0] hi; icn_pins_t pins; icn_pins_t ev;} icn_row_t;
  logic        mclk_i = 1'b0, sys_rst_i = 1'b1, clr = 1'b0, notice;
  logic [15:0] en_lo = '0, en_hi = '0, pu_lo = '0, pu_hi = '0;
  icn_pins_t   drv_en = '1, drv = '0, pin, pu_on, ev;
  int          n_fail = 0, check_count = 0;
  // pin levels are absolute; each row changes them after the previous row
  icn_row_t rows[5] = '{'{16'hFFFF, 16'h0000, 30'h00000001, 30'h00000001},
    '{16'h0000, 16'h3FFF, 30'h00000003, 30'h00000000},
    '{16'h0000, 16'h2000, 30'h20000003, 30'h20000000},
    '{16'h0000, 16'hC000, 30'h30000003, 30'h00000000},
    '{16'h0005, 16'h0001, 30'h30010006, 30'h00010005}};
  icn_notifier u_icn_notifier (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .change_watch_pin_i(pin),
    .change_irq_enable_low_i(en_lo), .change_irq_enable_high_i(en_hi), .weak_pullup_enable_low_i(pu_lo),
    .weak_pullup_enable_high_i(pu_hi), .notice_clear_i(clr), .pullup_on_o(pu_on),
    .state_change_event_o(ev), .input_change_notice_o(notice));
  icn_pin_model u_icn_pin_model (.drv_en_i(drv_en), .drv_val_i(drv), .pullup_on_i(pu_on), .pin_o(pin));
  always #5 mclk_i = ~mclk_i;
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : step
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
  initial begin
    step(20);
    sys_rst_i = 1'b0;
    chk("notice", 0, notice);
    // every level held at least the least hold time of four cycles
    foreach (rows[r]) begin
      {en_lo, en_hi, clr} = {rows[r].lo, rows[r].hi, 1'b1};
      step(1);
      {drv, clr} = {rows[r].pins, 1'b0};
      step(3);
      chk("event", rows[r].ev, ev);
      chk("notice", {31'h0, |rows[r].ev}, notice);
    end
    step(1);
    chk("event", 0, ev);
    chk("notice", 1, notice);
    // clear lands on the edge that brings a new change
    drv[2] = 1'b0;
    step(2);
    clr = 1'b1;
    step(1);
    chk("notice", 1, notice);
    step(1);
    clr = 1'b0;
    chk("notice", 0, notice);
    // pull-up only on a released pin
    {pu_lo, pu_hi} = {16'h0004, 16'hC000};
    step(1);
    chk("pullup", 30'h00000004, pu_on);
    drv_en[2] = 1'b0;
    step(3);
    chk("event", 30'h00000004, ev);
    sys_rst_i = 1'b1;
    step(1);
    chk("pullup", 0, pu_on);
    chk("notice", 0, notice);
    finish_test();
  end
endmodule : tb_input_change_notifier
`default_nettype wire
